// ===== lcrio_top.sv
`timescale 1ns/1ps
`include "lcrio_defines.svh"
module lcrio_top import lcrio_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic meas_valid,
  input wire logic [1:0] meas_chan,
  input wire logic [23:0] meas_raw,
  input wire logic discrete_in_a,
  input wire logic discrete_in_b,
  input wire logic discrete_in_c,
  input wire logic discrete_in_d,
  output logic discrete_out_a,
  output logic discrete_out_b,
  output logic discrete_out_c,
  output logic discrete_out_d
);
  lcrio_regs_t r, next_r;
  logic calc_in;
  logic calc_valid;
  logic [1:0] calc_chan;
  logic [23:0] calc_raw;
  logic [31:0] calc_weight;
  logic [55:0] mem_rd;
  logic setup;
  logic access;
  logic mapped;
  logic rd_hold;
  logic [7:0] pin_state_word;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = a == `LCRIO_OFS_DATA || a == `LCRIO_OFS_STAT ||
      a == `LCRIO_OFS_CHAN || a == `LCRIO_OFS_CSEL ||
      a == `LCRIO_OFS_SCALE || a == `LCRIO_OFS_GAIN ||
      a == `LCRIO_OFS_TARE || a == `LCRIO_OFS_REF;
  endfunction

  assign calc_in = meas_valid && r.chan_act[meas_chan];

  lcrio_calc u_calc (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(calc_in),
    .in_chan(meas_chan),
    .raw(meas_raw),
    .scale(r.scale[meas_chan]),
    .gain(r.gain[meas_chan]),
    .tare(r.tare[meas_chan]),
    .refo(r.refo[meas_chan]),
    .out_valid(calc_valid),
    .out_chan(calc_chan),
    .out_raw(calc_raw),
    .weight(calc_weight)
  );

  lcrio_mem #(
    .WIDTH(56),
    .DEPTH(4)
  ) u_mem (
    .sys_clk(sys_clk),
    .we(calc_valid),
    .wr_addr(calc_chan),
    .wr_data({calc_weight, calc_raw}),
    .rd_addr(r.sel),
    .rd_data(mem_rd)
  );

  assign setup = psel && !penable;
  assign access = psel && penable && r.pready;
  assign mapped = is_mapped(paddr);
  // a pending host read of the data word freezes the output register
  assign rd_hold = psel && !pwrite && paddr == `LCRIO_OFS_DATA;
  assign pin_state_word = {~r.sync2, ~r.dout};

  always_comb begin
    next_r = r;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    next_r.sync1 = {discrete_in_d, discrete_in_c, discrete_in_b, discrete_in_a};
    next_r.sync2 = r.sync1;

    // command interpreter
    case (r.state)
      ST_IDLE: begin
        if (r.ibf) begin
          next_r.ibf = 1'b0;
          next_r.cmd = r.in_byte;
          case (r.in_byte)
            `LCRIO_CMD_WEIGHT: begin
              next_r.state = ST_CHAN;
            end
            `LCRIO_CMD_RAW: begin
              next_r.state = ST_CHAN;
            end
            `LCRIO_CMD_IOGET: begin
              next_r.tx = {24'h0, pin_state_word};
              next_r.tx_left = `LCRIO_IO_BYTES;
              next_r.state = ST_SEND;
            end
            `LCRIO_CMD_IOSET: begin
              next_r.state = ST_SETLO;
            end
            default: begin
              next_r.state = ST_IDLE;
            end
          endcase
        end
      end
      ST_CHAN: begin
        if (r.ibf) begin
          next_r.ibf = 1'b0;
          next_r.sel = r.in_byte[1:0];
          next_r.state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        next_r.state = ST_LOAD;
      end
      ST_LOAD: begin
        if (r.cmd == `LCRIO_CMD_RAW) begin
          next_r.tx = {8'h0, mem_rd[23:0]};
          next_r.tx_left = `LCRIO_RAW_BYTES;
        end else begin
          next_r.tx = mem_rd[55:24];
          next_r.tx_left = `LCRIO_WEIGHT_BYTES;
        end
        next_r.state = ST_SEND;
      end
      ST_SEND: begin
        if (!r.obf && !rd_hold) begin
          next_r.out_byte = r.tx[7:0];
          next_r.obf = 1'b1;
          next_r.tx = {8'h0, r.tx[31:8]};
          next_r.tx_left = r.tx_left - 3'h1;
          if (r.tx_left == 3'h1) begin
            next_r.state = ST_IDLE;
          end
        end
      end
      ST_SETLO: begin
        if (r.ibf) begin
          next_r.ibf = 1'b0;
          next_r.set_lo = r.in_byte[3:0];
          next_r.state = ST_SETHI;
        end
      end
      ST_SETHI: begin
        if (r.ibf) begin
          next_r.ibf = 1'b0;
          next_r.dout = r.set_lo;
          next_r.state = ST_IDLE;
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase

    // apb setup: registered answer in the access cycle
    if (setup) begin
      next_r.pready = 1'b1;
      next_r.pslverr = !mapped ||
        (pwrite && paddr == `LCRIO_OFS_DATA && r.ibf);
      next_r.prdata = 32'h0;
      case (paddr)
        `LCRIO_OFS_DATA: begin
          next_r.prdata = {24'h0, r.out_byte};
        end
        `LCRIO_OFS_STAT: begin
          next_r.prdata = {30'h0, r.obf, r.ibf};
        end
        `LCRIO_OFS_CHAN: begin
          next_r.prdata = {28'h0, r.chan_act};
        end
        `LCRIO_OFS_CSEL: begin
          next_r.prdata = {30'h0, r.csel};
        end
        `LCRIO_OFS_SCALE: begin
          next_r.prdata = {16'h0, r.scale[r.csel]};
        end
        `LCRIO_OFS_GAIN: begin
          next_r.prdata = {16'h0, r.gain[r.csel]};
        end
        `LCRIO_OFS_TARE: begin
          next_r.prdata = {8'h0, r.tare[r.csel]};
        end
        `LCRIO_OFS_REF: begin
          next_r.prdata = {8'h0, r.refo[r.csel]};
        end
        default: begin
          next_r.prdata = 32'h0;
        end
      endcase
    end

    // apb access edge: writes and read side effects
    if (access && pwrite) begin
      case (paddr)
        `LCRIO_OFS_DATA: begin
          if (!r.ibf) begin
            next_r.in_byte = pwdata[7:0];
            next_r.ibf = 1'b1;
          end
        end
        `LCRIO_OFS_CHAN: begin
          next_r.chan_act = pwdata[3:0];
        end
        `LCRIO_OFS_CSEL: begin
          next_r.csel = pwdata[1:0];
        end
        `LCRIO_OFS_SCALE: begin
          next_r.scale[r.csel] = pwdata[15:0];
        end
        `LCRIO_OFS_GAIN: begin
          next_r.gain[r.csel] = pwdata[15:0];
        end
        `LCRIO_OFS_TARE: begin
          next_r.tare[r.csel] = pwdata[23:0];
        end
        `LCRIO_OFS_REF: begin
          next_r.refo[r.csel] = pwdata[23:0];
        end
        default: begin
          next_r.csel = r.csel;
        end
      endcase
    end else if (access && paddr == `LCRIO_OFS_DATA) begin
      next_r.obf = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r <= '0;
      r.state <= ST_IDLE;
      r.chan_act <= `LCRIO_RST_CHAN;
      r.dout <= `LCRIO_RST_OUT;
      r.set_lo <= `LCRIO_RST_OUT;
      r.scale <= {4{`LCRIO_RST_SCALE}};
      r.gain <= {4{`LCRIO_RST_GAIN}};
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign discrete_out_a = r.dout[0];
  assign discrete_out_b = r.dout[1];
  assign discrete_out_c = r.dout[2];
  assign discrete_out_d = r.dout[3];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  chk_ibf_set: assert property (
    access && pwrite && paddr == `LCRIO_OFS_DATA && !r.ibf |=> r.ibf)
    else $error("input buffer not flagged full");
  chk_ibf_refuse: assert property (
    access && pwrite && paddr == `LCRIO_OFS_DATA && r.ibf |-> pslverr)
    else $error("write into full buffer not refused");
  chk_obf_clear: assert property (
    access && !pwrite && paddr == `LCRIO_OFS_DATA |=> !r.obf)
    else $error("output flag not cleared by read");
  chk_obf_load: assert property (
    r.state == ST_SEND && !r.obf && !rd_hold |=> r.obf && r.out_byte == $past(r.tx[7:0]))
    else $error("response byte not placed");
  chk_raw_three: assert property (
    r.state == ST_LOAD && r.cmd == `LCRIO_CMD_RAW |=> r.tx_left == 3'h3 && r.tx[31:24] == 8'h0)
    else $error("raw reply not three bytes");
  chk_io_snapshot: assert property (
    r.state == ST_IDLE && r.ibf && r.in_byte == `LCRIO_CMD_IOGET
    |=> r.tx[7:0] == {~$past(r.sync2), ~$past(r.dout)})
    else $error("io snapshot wrong");
  chk_out_update: assert property (
    r.state == ST_SETHI && r.ibf |=> r.dout == $past(r.set_lo))
    else $error("outputs not updated together");
  chk_out_hold: assert property (
    !(r.state == ST_SETHI && r.ibf) |=> $stable(r.dout))
    else $error("outputs changed without command");
  chk_inactive_skip: assert property (
    meas_valid && !r.chan_act[meas_chan] |=> !calc_valid)
    else $error("inactive channel measured");
  chk_ref_trunc: assert property (
    access && pwrite && paddr == `LCRIO_OFS_REF
    |=> r.refo[$past(r.csel)] == $past(pwdata[23:0]))
    else $error("reference offset not stored");
  chk_weight_sel: assert property (
    r.state == ST_LOAD && r.cmd == `LCRIO_CMD_WEIGHT |=> r.tx == $past(mem_rd[55:24]))
    else $error("weight not the stored result");
  chk_stat_read: assert property (
    setup && paddr == `LCRIO_OFS_STAT |=> pready && prdata[1:0] == {$past(r.obf), $past(r.ibf)})
    else $error("status read wrong");
  chk_cmd_consume: assert property (
    r.state == ST_IDLE && r.ibf |=> !r.ibf)
    else $error("command byte not consumed");
  chk_chan_select: assert property (
    r.state == ST_CHAN && r.ibf |=> r.sel == $past(r.in_byte[1:0]) && r.state == ST_FETCH)
    else $error("channel byte not taken");
  chk_raw_bytes: assert property (
    r.state == ST_LOAD && r.cmd == `LCRIO_CMD_RAW |=> r.tx[23:0] == $past(mem_rd[23:0]))
    else $error("raw reply not the stored result");
  chk_setlo_capture: assert property (
    r.state == ST_SETLO && r.ibf |=> r.set_lo == $past(r.in_byte[3:0]) && $stable(r.dout))
    else $error("low output byte not held");
  chk_send_last: assert property (
    r.state == ST_SEND && r.tx_left == 3'h1 && !r.obf && !rd_hold |=> r.state == ST_IDLE)
    else $error("reply longer than counted");
  chk_unmapped_err: assert property (
    setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_pready_once: assert property (
    pready |=> !pready)
    else $error("pready longer than one cycle");

  cov_weight_req: cover property (r.state == ST_LOAD && r.cmd == `LCRIO_CMD_WEIGHT);
  cov_raw_req: cover property (r.state == ST_LOAD && r.cmd == `LCRIO_CMD_RAW);
  cov_io_set: cover property (r.state == ST_SETHI && r.ibf);
  cov_io_get: cover property (r.state == ST_IDLE && r.ibf && r.in_byte == `LCRIO_CMD_IOGET);
  cov_buf_refused: cover property (access && pwrite && paddr == `LCRIO_OFS_DATA && r.ibf);
endmodule

// ===== lcrio_defines.svh
`ifndef LCRIO_DEFINES_SVH
`define LCRIO_DEFINES_SVH
`define LCRIO_OFS_DATA 8'h00
`define LCRIO_OFS_STAT 8'h04
`define LCRIO_OFS_CHAN 8'h08
`define LCRIO_OFS_CSEL 8'h0c
`define LCRIO_OFS_SCALE 8'h10
`define LCRIO_OFS_GAIN 8'h14
`define LCRIO_OFS_TARE 8'h18
`define LCRIO_OFS_REF 8'h1c
`define LCRIO_CMD_WEIGHT 8'h01
`define LCRIO_CMD_RAW 8'h02
`define LCRIO_CMD_IOGET 8'h03
`define LCRIO_CMD_IOSET 8'h04
`define LCRIO_RST_CHAN 4'hf
`define LCRIO_RST_OUT 4'hf
`define LCRIO_RST_SCALE 16'h0001
`define LCRIO_RST_GAIN 16'h0001
`define LCRIO_RAW_BYTES 3'h3
`define LCRIO_WEIGHT_BYTES 3'h4
`define LCRIO_IO_BYTES 3'h1
`endif

// ===== lcrio_pkg.sv
package lcrio_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHAN = 3'b001,
    ST_FETCH = 3'b010,
    ST_LOAD = 3'b011,
    ST_SEND = 3'b100,
    ST_SETLO = 3'b101,
    ST_SETHI = 3'b110
  } lcrio_state_t;

  typedef struct packed {
    lcrio_state_t state;
    logic [7:0] cmd;
    logic [1:0] sel;
    logic ibf;
    logic obf;
    logic [7:0] in_byte;
    logic [7:0] out_byte;
    logic [31:0] tx;
    logic [2:0] tx_left;
    logic [3:0] chan_act;
    logic [1:0] csel;
    logic [3:0][15:0] scale;
    logic [3:0][15:0] gain;
    logic [3:0][23:0] tare;
    logic [3:0][23:0] refo;
    logic [3:0] dout;
    logic [3:0] set_lo;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lcrio_regs_t;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [23:0] raw;
    logic [31:0] weight;
  } lcrio_calc_t;
endpackage

// ===== lcrio_mem.sv
`timescale 1ns/1ps
module lcrio_mem import lcrio_pkg::*; #(
  parameter int WIDTH = 56,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // latest result per channel, read one cycle later
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== lcrio_calc.sv
`timescale 1ns/1ps
module lcrio_calc import lcrio_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [1:0] in_chan,
  input wire logic [23:0] raw,
  input wire logic [15:0] scale,
  input wire logic [15:0] gain,
  input wire logic [23:0] tare,
  input wire logic [23:0] refo,
  output logic out_valid,
  output logic [1:0] out_chan,
  output logic [23:0] out_raw,
  output logic [31:0] weight
);
  lcrio_calc_t r, next_r;
  logic signed [25:0] diff;
  logic signed [59:0] prod;

  always_comb begin
    diff = $signed({2'h0, raw}) - $signed({2'h0, refo}) - $signed({2'h0, tare});
    prod = $signed({1'b0, scale}) * $signed({1'b0, gain}) * diff;
    next_r = r;
    next_r.valid = in_valid;
    if (in_valid) begin
      next_r.chan = in_chan;
      next_r.raw = raw;
      next_r.weight = prod[31:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign out_valid = r.valid;
  assign out_chan = r.chan;
  assign out_raw = r.raw;
  assign weight = r.weight;

  chk_zero_net_weight: assert property (@(posedge sys_clk) disable iff (sys_rst)
    in_valid && raw == refo + tare && raw >= refo |=> weight == 32'h0)
    else $error("weight not zero at offset plus tare");
  chk_raw_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    in_valid |=> out_valid && out_raw == $past(raw))
    else $error("raw result not carried");
endmodule

// ===== lcrio_host.sv
`timescale 1ns/1ps
`include "lcrio_defines.svh"
module lcrio_host (
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one apb transfer, waits for pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    e = (pslverr !== 1'b0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // wait input buffer empty, then write byte
  task automatic put_byte(input logic [7:0] b, output logic ok);
    logic [31:0] r;
    logic e;
    ok = 1'b0;
    for (int n = 0; n < 40 && !ok; n++) begin
      xfer(1'b0, `LCRIO_OFS_STAT, 32'h0, r, e);
      ok = (r[0] === 1'b0);
    end
    if (ok) xfer(1'b1, `LCRIO_OFS_DATA, {24'h0, b}, r, e);
  endtask

  // wait output byte present, then read it
  task automatic get_byte(output logic [7:0] b, output logic ok);
    logic [31:0] r;
    logic e;
    ok = 1'b0;
    b = 8'h00;
    for (int n = 0; n < 40 && !ok; n++) begin
      xfer(1'b0, `LCRIO_OFS_STAT, 32'h0, r, e);
      ok = (r[1] === 1'b1);
    end
    if (ok) begin
      xfer(1'b0, `LCRIO_OFS_DATA, 32'h0, r, e);
      b = r[7:0];
    end
  endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`include "lcrio_defines.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, meas_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] meas_chan;
  logic [23:0] meas_raw;
  logic [3:0] din, dout;
  int n_errors = 0;
  int n_checks = 0;

  lcrio_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_raw(meas_raw),
    .discrete_in_a(din[0]), .discrete_in_b(din[1]), .discrete_in_c(din[2]),
    .discrete_in_d(din[3]), .discrete_out_a(dout[0]), .discrete_out_b(dout[1]),
    .discrete_out_c(dout[2]), .discrete_out_d(dout[3]));
  lcrio_host h (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    h.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rdreg(input logic [7:0] a, output logic [31:0] r, output logic e);
    h.xfer(1'b0, a, 32'h0, r, e);
  endtask

  task automatic req(input logic [7:0] c, input logic [7:0] ch, input bit with_ch);
    logic ok;
    h.put_byte(c, ok);
    `CHK(ok, 1'b1)
    if (with_ch) begin
      h.put_byte(ch, ok);
      `CHK(ok, 1'b1)
    end
  endtask

  task automatic rd_bytes(input int n, output logic [31:0] v);
    logic [7:0] b;
    logic ok;
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      h.get_byte(b, ok);
      `CHK(ok, 1'b1)
      v[8*i+:8] = b;
    end
  endtask

  task automatic meas(input logic [1:0] c, input logic [23:0] r);
    meas_chan <= c;
    meas_raw <= r;
    meas_valid <= 1'b1;
    @(posedge sys_clk);
    meas_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic t_raw();
    logic [31:0] v;
    logic e;
    meas(2'd1, 24'h08fa5c);
    req(`LCRIO_CMD_RAW, 8'h01, 1);
    rd_bytes(3, v);
    `CHK(v, 32'h0008fa5c)
    rdreg(`LCRIO_OFS_STAT, v, e);
    `CHK(v[1], 1'b0)
    $display("test raw done");
  endtask

  task automatic t_weight();
    logic [31:0] v;
    logic e;
    wr(`LCRIO_OFS_CSEL, 32'h2);
    wr(`LCRIO_OFS_SCALE, 32'h3);
    wr(`LCRIO_OFS_GAIN, 32'h2);
    wr(`LCRIO_OFS_TARE, 32'h5);
    wr(`LCRIO_OFS_REF, 32'h11000010);
    rdreg(`LCRIO_OFS_REF, v, e);
    `CHK(v, 32'h00000010)
    meas(2'd2, 24'h000100);
    req(`LCRIO_CMD_WEIGHT, 8'h02, 1);
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 2; i++) begin
      rdreg(`LCRIO_OFS_STAT, v, e);
      `CHK(v[1], 1'b1)
    end
    rd_bytes(4, v);
    `CHK(v, 32'd1410)
    meas(2'd2, 24'h000008);
    for (int i = 0; i < 2; i++) begin
      req(`LCRIO_CMD_WEIGHT, 8'h02, 1);
      rd_bytes(4, v);
      `CHK(v, 32'hffffffb2)
    end
    meas(2'd2, 24'h000015);
    req(`LCRIO_CMD_WEIGHT, 8'h02, 1);
    rd_bytes(4, v);
    `CHK(v, 32'h0)
    $display("test weight done");
  endtask

  task automatic t_active();
    logic [31:0] v;
    logic e;
    meas(2'd3, 24'h000abc);
    wr(`LCRIO_OFS_CHAN, 32'h7);
    rdreg(`LCRIO_OFS_CHAN, v, e);
    `CHK(v, 32'h7)
    meas(2'd3, 24'h000def);
    req(`LCRIO_CMD_RAW, 8'h03, 1);
    h.xfer(1'b1, `LCRIO_OFS_DATA, 32'h0, v, e);
    `CHK(e, 1'b0)
    h.xfer(1'b1, `LCRIO_OFS_DATA, {24'h0, `LCRIO_CMD_IOGET}, v, e);
    `CHK(e, 1'b1)
    rd_bytes(3, v);
    `CHK(v, 32'h00000abc)
    rdreg(`LCRIO_OFS_STAT, v, e);
    `CHK(v[1:0], 2'b00)
    wr(`LCRIO_OFS_CHAN, 32'hf);
    rdreg(8'h20, v, e);
    `CHK(e, 1'b1)
    `CHK(v, 32'h0)
    $display("test active done");
  endtask

  task automatic t_io();
    logic [31:0] v;
    logic ok;
    din <= 4'b0110;
    req(`LCRIO_CMD_IOSET, 8'hf5, 1);
    repeat (4) @(posedge sys_clk);
    `CHK(dout, 4'hf)
    h.put_byte(8'h00, ok);
    `CHK(ok, 1'b1)
    repeat (4) @(posedge sys_clk);
    `CHK(dout, 4'h5)
    req(`LCRIO_CMD_IOGET, 8'h00, 0);
    rd_bytes(1, v);
    `CHK(v[7:0], 8'h9a)
    $display("test io done");
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    meas_valid = 1'b0;
    meas_chan = 2'd0;
    meas_raw = 24'h0;
    din = 4'hf;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    `CHK(dout, 4'hf)
    t_raw();
    t_weight();
    t_active();
    t_io();
    give_verdict();
  end
endmodule
